// >>> core/acs_regs.vh
// Purpose: constants for the converter sequencer (register map, fields, timing)
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// register byte offsets
`define ACS_OFF_CTRL0      8'h00
`define ACS_OFF_CTRL1      8'h04
`define ACS_OFF_PINEN      8'h08
`define ACS_OFF_IRQ        8'h0C
`define ACS_OFF_RES_LO     8'h10
`define ACS_OFF_RES_HI     8'h14

// conv_control_zero fields
`define ACS_C0_START       7
`define ACS_C0_BUSY        6
`define ACS_C0_PDOWN       5
`define ACS_C0_CHLO_MSB    2
`define ACS_C0_CHLO_LSB    0
// conv_control_one fields
`define ACS_C1_CHHI        7
`define ACS_C1_VREF        3
`define ACS_C1_DIV_MSB     2
`define ACS_C1_DIV_LSB     0
// irq control fields
`define ACS_IRQ_GIE        0
`define ACS_IRQ_EN         1
`define ACS_IRQ_FLAG       2

// reset values
`define ACS_RST_PDOWN      1'b1
`define ACS_RST_BYTE       8'h00
`define ACS_RST_RESULT     12'h000

// conversion timing in converter clock periods, and SAR trial codes
`define ACS_CONV_PERIODS   5'h10
`define ACS_SAMPLE_PERIODS 4'h4
`define ACS_LAST_STEP      4'hF
`define ACS_SAR_FIRST      12'h800
`define ACS_SAR_LSB        12'h001

// axi responses
`define ACS_RESP_OKAY      2'b00
`define ACS_RESP_SLVERR    2'b10

`endif

// >>> core/acs_sequencer.v
// Purpose: 12-bit successive-approximation converter sequencer with AXI4-Lite registers
// Assumes: comparator and analog mux are outside; cmp_above is synchronous to sys_clk
// Notes:   one clock domain, no clock enable, registers sit in the low byte of each word
`timescale 1ns/1ns
`include "acs_regs.vh"

////////////////////////////////////////////////////////////////////////////////
module acs_sequencer #(
   parameter DIV_W = 3,
   parameter RES_W = 12
) (
   input  wire              sys_clk,
   input  wire              nrst,
   input  wire [7:0]        s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output wire              s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output wire              s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [7:0]        s_axi_araddr,
   input  wire              s_axi_arvalid,
   output wire              s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   input  wire              cmp_above,
   input  wire              cpu_stack_full,
   output wire [4:0]        channel_select,
   output wire [7:0]        analog_pin_enables,
   output wire              conv_power_down,
   output wire              vref_external,
   output wire              conv_sample,
   output wire              conv_reset,
   output wire [RES_W-1:0]  sar_trial_code,
   output wire              conv_irq
);

   localparam ST_IDLE = 2'b00;
   localparam ST_HOLD = 2'b01;
   localparam ST_RUN  = 2'b10;

   // divider terminal count for a select code
   function [6:0] div_limit;
      input [DIV_W-1:0] sel;
      begin
         div_limit = (7'h01 << sel) - 7'h01;
      end
   endfunction

   // control registers
   reg              start_q;
   reg              pdown_q;
   reg [2:0]        ch_lo_q;
   reg              ch_hi_q;
   reg              vref_q;
   reg [DIV_W-1:0]  div_q;
   reg [7:0]        pinen_q;
   reg              gie_q;
   reg              irq_en_q;
   reg              flag_q;
   reg              busy_q;
   reg [RES_W-1:0]  result_q;
   // sequencer state
   reg [1:0]        state_q;
   reg [6:0]        div_cnt_q;
   reg [3:0]        step_q;
   reg [RES_W-1:0]  trial_q;
   reg [RES_W-1:0]  mask_q;
   // bus state
   reg              aw_hold_q;
   reg              w_hold_q;
   reg [7:0]        awaddr_q;
   reg [7:0]        wbyte_q;
   reg              wlane_q;

   ////////////////////////////////////////////////////////////////////////////
   // bus handshakes
   assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   wire do_write = aw_hold_q & w_hold_q;
   wire wr_ctrl0 = do_write & wlane_q & (awaddr_q == `ACS_OFF_CTRL0);
   wire wr_ctrl1 = do_write & wlane_q & (awaddr_q == `ACS_OFF_CTRL1);
   wire wr_pinen = do_write & wlane_q & (awaddr_q == `ACS_OFF_PINEN);
   wire wr_irq   = do_write & wlane_q & (awaddr_q == `ACS_OFF_IRQ);
   wire wr_known = (awaddr_q == `ACS_OFF_CTRL0) | (awaddr_q == `ACS_OFF_CTRL1) |
                   (awaddr_q == `ACS_OFF_PINEN) | (awaddr_q == `ACS_OFF_IRQ) |
                   (awaddr_q == `ACS_OFF_RES_LO) | (awaddr_q == `ACS_OFF_RES_HI);

   // start edge detection on the written value
   wire start_d    = wr_ctrl0 ? wbyte_q[`ACS_C0_START] : start_q;
   wire start_fall = start_q & ~start_d;
   wire pdown_d    = wr_ctrl0 ? wbyte_q[`ACS_C0_PDOWN] : pdown_q;

   ////////////////////////////////////////////////////////////////////////////
   // converter clock and conversion sequencing
   wire adck_tick = (div_cnt_q >= div_limit(div_q));
   wire decide    = (state_q == ST_RUN) & adck_tick & (step_q >= `ACS_SAMPLE_PERIODS);
   wire [RES_W-1:0] kept = cmp_above ? trial_q : (trial_q & ~mask_q);
   wire finish    = decide & (step_q == `ACS_LAST_STEP) & ~start_d & ~pdown_d;

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q   <= ST_IDLE;
         div_cnt_q <= 7'h00;
         step_q    <= 4'h0;
         trial_q   <= `ACS_RST_RESULT;
         mask_q    <= `ACS_RST_RESULT;
         busy_q    <= 1'b0;
         result_q  <= `ACS_RST_RESULT;
      end else begin
         if (adck_tick || state_q != ST_RUN)
            div_cnt_q <= 7'h00;
         else
            div_cnt_q <= div_cnt_q + 7'h01;
         case (state_q)
            ST_IDLE, ST_HOLD: begin
               if (start_d) begin
                  state_q <= ST_HOLD;
                  busy_q  <= 1'b1;
               end else if (start_fall && !pdown_d) begin
                  state_q <= ST_RUN;
                  busy_q  <= 1'b1;
                  step_q  <= 4'h0;
               end else if (state_q == ST_HOLD) begin
                  // powered down at release: nothing to convert
                  state_q <= ST_IDLE;
                  busy_q  <= 1'b0;
               end
            end
            ST_RUN: begin
               if (start_d || pdown_d) begin
                  state_q <= start_d ? ST_HOLD : ST_IDLE;
                  busy_q  <= start_d;
               end else if (adck_tick) begin
                  step_q <= step_q + 4'h1;
                  if (step_q == `ACS_SAMPLE_PERIODS - 4'h1) begin
                     trial_q <= `ACS_SAR_FIRST;
                     mask_q  <= `ACS_SAR_FIRST;
                  end
                  if (decide) begin
                     trial_q <= kept | (mask_q >> 1);
                     mask_q  <= mask_q >> 1;
                  end
                  if (finish) begin
                     state_q  <= ST_IDLE;
                     busy_q   <= 1'b0;
                     result_q <= kept;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy_q  <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software registers
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         start_q  <= 1'b0;
         pdown_q  <= `ACS_RST_PDOWN;
         ch_lo_q  <= 3'b000;
         ch_hi_q  <= 1'b0;
         vref_q   <= 1'b0;
         div_q    <= {DIV_W{1'b0}};
         pinen_q  <= `ACS_RST_BYTE;
         gie_q    <= 1'b0;
         irq_en_q <= 1'b0;
         flag_q   <= 1'b0;
      end else begin
         start_q <= start_d;
         if (wr_ctrl0) begin
            pdown_q <= wbyte_q[`ACS_C0_PDOWN];
            ch_lo_q <= wbyte_q[`ACS_C0_CHLO_MSB:`ACS_C0_CHLO_LSB];
         end
         if (wr_ctrl1) begin
            ch_hi_q <= wbyte_q[`ACS_C1_CHHI];
            vref_q  <= wbyte_q[`ACS_C1_VREF];
            div_q   <= wbyte_q[`ACS_C1_DIV_MSB:`ACS_C1_DIV_LSB];
         end
         if (wr_pinen)
            pinen_q <= wbyte_q;
         if (wr_irq) begin
            gie_q    <= wbyte_q[`ACS_IRQ_GIE];
            irq_en_q <= wbyte_q[`ACS_IRQ_EN];
         end
         // completion sets flag; set beats clear
         if (finish)
            flag_q <= 1'b1;
         else if (wr_irq)
            flag_q <= wbyte_q[`ACS_IRQ_FLAG];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write channel
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         aw_hold_q    <= 1'b0;
         w_hold_q     <= 1'b0;
         awaddr_q     <= 8'h00;
         wbyte_q      <= 8'h00;
         wlane_q      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `ACS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wbyte_q  <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read channel
   reg [7:0] rd_byte;
   reg       rd_known;
   always @* begin
      rd_byte  = 8'h00;
      rd_known = 1'b1;
      case (s_axi_araddr)
         `ACS_OFF_CTRL0: begin
            rd_byte[`ACS_C0_START] = start_q;
            rd_byte[`ACS_C0_BUSY]  = busy_q;
            rd_byte[`ACS_C0_PDOWN] = pdown_q;
            rd_byte[`ACS_C0_CHLO_MSB:`ACS_C0_CHLO_LSB] = ch_lo_q;
         end
         `ACS_OFF_CTRL1: begin
            rd_byte[`ACS_C1_CHHI] = ch_hi_q;
            rd_byte[`ACS_C1_VREF] = vref_q;
            rd_byte[`ACS_C1_DIV_MSB:`ACS_C1_DIV_LSB] = div_q;
         end
         `ACS_OFF_PINEN:
            rd_byte = pinen_q;
         `ACS_OFF_IRQ: begin
            rd_byte[`ACS_IRQ_GIE]  = gie_q;
            rd_byte[`ACS_IRQ_EN]   = irq_en_q;
            rd_byte[`ACS_IRQ_FLAG] = flag_q;
         end
         `ACS_OFF_RES_LO:
            rd_byte = result_q[7:0];
         `ACS_OFF_RES_HI:
            rd_byte = {4'h0, result_q[RES_W-1:8]};
         default:
            rd_known = 1'b0;
      endcase
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `ACS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, rd_byte};
         s_axi_rresp  <= rd_known ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // analog side controls
   // channel bits from both controls
   assign channel_select     = {ch_hi_q, 1'b0, ch_lo_q};
   assign analog_pin_enables = pinen_q;
   assign conv_power_down    = pdown_q;
   assign vref_external      = vref_q;
   assign conv_sample        = (state_q == ST_RUN) & (step_q < `ACS_SAMPLE_PERIODS);
   assign conv_reset         = (state_q != ST_RUN);
   assign sar_trial_code     = trial_q;
   assign conv_irq           = flag_q & irq_en_q & gie_q & ~cpu_stack_full;

endmodule // acs_sequencer

// >>> sim/acs_cmp_model.sv
// Purpose: comparator and analog input stand-in for the sequencer
// Assumes: input level given in whole result steps
// Notes:   answer wanders while the converter is off or held
`timescale 1ns/1ns
module acs_cmp_model (
   input  wire logic        sys_clk,
   input  wire logic        conv_power_down,
   input  wire logic        conv_reset,
   input  wire logic [11:0] sar_trial_code,
   input  wire logic [11:0] level,
   output logic             cmp_above
);
   logic tog_q = 1'b0;

   always @(posedge sys_clk) begin
      tog_q <= ~tog_q;
   end

   assign cmp_above = (conv_power_down || conv_reset) ? tog_q : (level >= sar_trial_code);
endmodule // acs_cmp_model

// >>> sim/acs_sequencer_sva.sv
// Purpose: port-level properties of the converter sequencer
// Assumes: one clock, reset active low and asynchronous
// Notes:   run bound uses the slowest divider code
`timescale 1ns/1ns
module acs_sequencer_sva #(
   parameter RES_W = 12
) (
   input wire logic             sys_clk,
   input wire logic             nrst,
   input wire logic [1:0]       s_axi_bresp,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready,
   input wire logic             s_axi_arready,
   input wire logic [31:0]      s_axi_rdata,
   input wire logic             s_axi_rvalid,
   input wire logic             s_axi_rready,
   input wire logic             cpu_stack_full,
   input wire logic [4:0]       channel_select,
   input wire logic             conv_power_down,
   input wire logic             conv_sample,
   input wire logic             conv_reset,
   input wire logic [RES_W-1:0] sar_trial_code,
   input wire logic             conv_irq
);
   logic [11:0] run_q;

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) run_q <= 12'h000;
      else if (conv_reset) run_q <= 12'h000;
      else run_q <= run_q + 12'h001;
   end

   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   ////////////////////////////////////////////////////////////
   a_irq_stack: assert property (conv_irq |-> !cpu_stack_full)
      else $error("irq while stack full");
   a_pdown_off: assert property (conv_power_down |-> conv_reset)
      else $error("converter active while off");
   a_conv_len: assert property (run_q <= 12'h800)
      else $error("conversion too long");
   a_sample_run: assert property ($fell(conv_reset) |-> conv_sample [*4])
      else $error("sampling window short");
   a_first_trial: assert property ($fell(conv_sample) && !conv_reset |-> sar_trial_code == 12'h800)
      else $error("first trial code wrong");
   a_chan_gap: assert property (channel_select[3] == 1'b0)
      else $error("reserved channel bit set");
   a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");

   c_irq: cover property ($rose(conv_irq));
   c_start: cover property ($fell(conv_reset));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // acs_sequencer_sva

bind acs_sequencer acs_sequencer_sva #(.RES_W(RES_W)) sva_u (.*);

// >>> sim/acs_sequencer_tb.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: 25 MHz clock, one register byte per word
// Notes:   every divider code is swept, so the slowest run lasts 2048 cycles
`timescale 1ns/1ns
module acs_sequencer_tb;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, analog_pin_enables;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, dat;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cpu_stack_full = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        conv_power_down, vref_external, conv_sample, conv_reset, conv_irq, cmp_above;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [4:0]  channel_select;
   logic [11:0] sar_trial_code, level = 12'h000, run_n = 12'h000, last_n = 12'h000;
   logic [11:0] lv [0:7] = '{12'hFFF, 12'h000, 12'hA5C, 12'h800, 12'h7FF, 12'h001, 12'h3C3, 12'hFFE};
   logic [25:0] rows [0:5] = '{{8'h04, 8'h8B, 8'h8B, 2'h0}, {8'h08, 8'h0F, 8'h0F, 2'h0},
      {8'h0C, 8'h06, 8'h06, 2'h0}, {8'h00, 8'h05, 8'h05, 2'h0}, {8'h14, 8'h3C, 8'h00, 2'h0},
      {8'h18, 8'h5A, 8'h00, 2'h2}};
   int          miscompares = 0, comparisons = 0, n;

   acs_sequencer dut_u (.*);
   acs_cmp_model cmp_u (.*);

   initial forever #20 sys_clk = ~sys_clk;

   // counts cycles out of converter reset
   always @(posedge sys_clk) begin
      if (!conv_reset) run_n <= run_n + 12'h001;
      else if (run_n != 12'h000) begin
         last_n <= run_n;
         run_n <= 12'h000;
      end
   end

   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic done(input string s);
      $display("test %s ended", s);
   endtask

   task automatic summarize;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a, dat, rsp);
      chk(dat, e);
   endtask

   task automatic do_reset;
      nrst <= 1'b0;
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
   endtask

   initial begin
      #(40 * 30000);
      miscompares++;
      summarize();
   end

   ////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      foreach (rows[i]) begin
         wr(rows[i][25:18], rows[i][17:10], rsp);
         chk(rsp, rows[i][1:0]);
         rd(rows[i][25:18], dat, rsp);
         chk(dat, rows[i][9:2]);
         chk(rsp, rows[i][1:0]);
      end
      chk(channel_select, 5'h15);
      chk(analog_pin_enables, 8'h0F);
      chk(vref_external, 1'b1);
      chk(conv_power_down, 1'b0);
      chk(conv_irq, 1'b0);
      done("registers");
      // irq enables and stack state vary with the divider code
      for (int d = 0; d < 8; d++) begin
         level <= lv[d];
         cpu_stack_full <= (d == 7);
         wr(8'h04, {5'h00, d[2:0]}, rsp);
         wr(8'h0C, {6'h00, d[1:0]}, rsp);
         wr(8'h00, 8'h80, rsp);
         rchk(8'h00, 32'h0000_00C0);
         wr(8'h00, 8'h00, rsp);
         rchk(8'h00, 32'h0000_0040);
         n = 0;
         do begin
            rd(8'h00, dat, rsp);
            n++;
         end while (dat[6] && n < 1000);
         chk(dat, 32'h0000_0000);
         chk(last_n, 32'h0000_0010 << d);
         rchk(8'h10, {24'h00_0000, lv[d][7:0]});
         rchk(8'h14, {28'h000_0000, lv[d][11:8]});
         rchk(8'h0C, {29'h0000_0000, 1'b1, d[1:0]});
         chk(conv_irq, d == 3);
      end
      done("conversions");
      wr(8'h04, 8'h07, rsp);
      wr(8'h0C, 8'h03, rsp);
      wr(8'h00, 8'h80, rsp);
      wr(8'h00, 8'h00, rsp);
      repeat (100) @(posedge sys_clk);
      wr(8'h00, 8'h20, rsp);
      chk(conv_reset, 1'b1);
      rchk(8'h00, 32'h0000_0020);
      rchk(8'h10, 32'h0000_00FE);
      rchk(8'h0C, 32'h0000_0003);
      done("abort");
      wr(8'h00, 8'h80, rsp);
      repeat (40) @(posedge sys_clk);
      chk(conv_reset, 1'b1);
      rchk(8'h00, 32'h0000_00C0);
      wr(8'h00, 8'h00, rsp);
      repeat (40) @(posedge sys_clk);
      do_reset();
      @(posedge sys_clk);
      chk(conv_power_down, 1'b1);
      chk(conv_reset, 1'b1);
      rchk(8'h00, 32'h0000_0020);
      rchk(8'h14, 32'h0000_0000);
      rchk(8'h0C, 32'h0000_0000);
      done("reset");
      summarize();
   end
endmodule // acs_sequencer_tb
